// file: logic/pnf_regs.svh
`ifndef PNF_REGS_SVH
`define PNF_REGS_SVH
// controller register offsets (byte addresses)
`define PNF_REG_CTRL 4'h0
`define PNF_REG_ADDR 4'h4
`define PNF_REG_WDATA 4'h8
`define PNF_REG_RDATA 4'hC
// control fields
`define PNF_CTRL_OP_LSB 0
`define PNF_CTRL_OP_MSB 2
`define PNF_CTRL_RST_BIT 3
// status fields (read of CTRL)
`define PNF_STAT_BUSY_BIT 0
`define PNF_STAT_RDY_BIT 1
`define PNF_STAT_TMO_BIT 2
`define PNF_STAT_DONE_BIT 3
`define PNF_STAT_ID_BIT 4
// command words
`define PNF_UNLOCK_A1 11'h555
`define PNF_UNLOCK_A2 11'h2AA
`define PNF_UNLOCK_D1 16'h00AA
`define PNF_UNLOCK_D2 16'h0055
`define PNF_CMD_RESET 16'h00F0
`define PNF_CMD_ID 16'h0090
`define PNF_CMD_PROG 16'h00A0
`define PNF_CMD_SETUP 16'h0080
`define PNF_CMD_CHIP 16'h0010
// timing: strobe phase length
`define PNF_PHASE_NS 100
`define PNF_PHASE_CYC ((`PNF_PHASE_NS + 9) / 10)
// reset pulse minimum
`define PNF_RESET_PULSE_MIN_NS 500
`define PNF_RESET_PULSE_CYC ((`PNF_RESET_PULSE_MIN_NS + 9) / 10)
`define PNF_RESET_RECOVER_CYC 8'd5
`endif

// file: logic/pnf_pkg.sv
package pnf_pkg;
  typedef enum logic [2:0] {
    PNF_OP_READ = 3'h0,
    PNF_OP_RESET = 3'h1,
    PNF_OP_ID = 3'h2,
    PNF_OP_PROG = 3'h3,
    PNF_OP_CHIP_ERASE = 3'h4,
    PNF_OP_POLL = 3'h5
  } pnf_op_t;
  typedef enum logic [2:0] {
    PNF_IDLE = 3'b000,
    PNF_SETUP = 3'b001,
    PNF_STROBE = 3'b011,
    PNF_HOLD = 3'b010,
    PNF_NEXT = 3'b110,
    PNF_HWRST = 3'b111,
    PNF_RECOVER = 3'b101
  } pnf_state_t;
endpackage : pnf_pkg

// file: logic/pnf_sync.sv
`timescale 1ns/10ps
// three-stage pin synchroniser; change accepted when stages 2 and 3 agree
module pnf_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b1;
    end else if (s2 == s3) begin
      q_o <= s3;
    end
  end
endmodule : pnf_sync

// file: logic/pnf_host.sv
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "pnf_regs.svh"
// =====================================================
// Function
// (R1) array read: chip select and output gate low, write strobe high.
// (R2) flash drives data only while output gate is low.
// (R3) flash starts in read-array mode after power-up or reset.
// (R4) flash stays in read-array until a command write.
// (R5) command write: strobe and select low, output gate high.
// (R6) wrong address or data in a sequence returns flash to read-array.
// (R7) identification codes read on the low data byte.
// (R8) output gate high puts flash data pins in high impedance.
// (R9) reset pin low at least minimum pulse aborts and returns to read.
// (R10) host restarts program or erase interrupted by hardware reset.
// (R11) ready/busy stays busy after reset during embedded operation.
// (R12) reset command aborts failed operation; host then issues valid command.
// (R13) identification: low bits 00 maker code, 01 device code.
// (R14) host writes reset command to leave identification mode.
// (R15) chip erase: two unlocks, setup, two unlocks, erase code.
// (R16) flash preprograms and erases chip with no host timing.
// (R17) erase ends on its own at sufficient margin.
// (R18) erase starts at rising strobe edge of final cycle.
// (R19) completion seen as poll bit one or toggle bit steady twice.
// (R20) erase failure sets timeout flag.
// (R21) erase-suspend reads in erasing sectors return status.
// (R22) after embedded algorithm flash is back in read-array.
// (R23) host writes reset command when timeout flag goes high.
// (R24) unlock cycles use fixed unlock addresses 555 and 2AA.
// (R25) ready/busy low while embedded algorithm runs.
module pnf_host (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic reset_n_o,
  output logic [19:0] fa_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] dq_i,
  input wire logic ready_busy_n_i
);
  // =====================================================
  // reset release
  logic rst_a;
  logic rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  logic rb_n;
  pnf_sync u_rb (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(ready_busy_n_i),
    .q_o(rb_n)
  );

  // =====================================================
  // registers
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic done;
  logic timeout_flag;
  logic id_mode;
  logic prev_toggle;
  logic have_prev;
  pnf_pkg::pnf_op_t op;
  pnf_pkg::pnf_state_t state;
  logic [2:0] step;
  logic [7:0] cnt;

  function automatic logic [2:0] seq_len(input pnf_pkg::pnf_op_t o);
    case (o)
      pnf_pkg::PNF_OP_RESET: seq_len = 3'd1;
      pnf_pkg::PNF_OP_ID: seq_len = 3'd3;
      pnf_pkg::PNF_OP_PROG: seq_len = 3'd4;
      pnf_pkg::PNF_OP_CHIP_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd1;
    endcase
  endfunction : seq_len

  // address and data of each command cycle
  function automatic logic [35:0] cyc_word(input pnf_pkg::pnf_op_t o, input logic [2:0] s,
                                           input logic [19:0] a, input logic [15:0] d);
    logic [10:0] ua;
    logic [15:0] ud;
    ua = `PNF_UNLOCK_A1;
    ud = `PNF_UNLOCK_D1;
    if (o == pnf_pkg::PNF_OP_RESET) begin
      ud = `PNF_CMD_RESET; // [R12] [R14] [R23]
    end else if (s == 3'd1 || s == 3'd4) begin
      ua = `PNF_UNLOCK_A2; // [R24]
      ud = `PNF_UNLOCK_D2;
    end else if (s == 3'd2) begin
      case (o)
        pnf_pkg::PNF_OP_ID: ud = `PNF_CMD_ID;
        pnf_pkg::PNF_OP_PROG: ud = `PNF_CMD_PROG;
        default: ud = `PNF_CMD_SETUP; // [R15]
      endcase
    end else if (s == 3'd5) begin
      ud = `PNF_CMD_CHIP; // [R15]
    end else if (s == 3'd3 && o == pnf_pkg::PNF_OP_PROG) begin
      cyc_word = {a, d};
      return cyc_word;
    end
    cyc_word = {9'h000, ua, ud};
  endfunction : cyc_word

  logic is_read;
  assign is_read = (op == pnf_pkg::PNF_OP_READ) || (op == pnf_pkg::PNF_OP_POLL);

  // =====================================================
  // register writes
  logic start;
  logic hw_reset_req;
  assign start = wr_i && addr_i == `PNF_REG_CTRL && state == pnf_pkg::PNF_IDLE
                 && !wdata_i[`PNF_CTRL_RST_BIT];
  assign hw_reset_req = wr_i && addr_i == `PNF_REG_CTRL && state == pnf_pkg::PNF_IDLE
                        && wdata_i[`PNF_CTRL_RST_BIT];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
    end else if (wr_i && addr_i == `PNF_REG_ADDR) begin
      addr_reg <= wdata_i[19:0];
    end else if (wr_i && addr_i == `PNF_REG_WDATA) begin
      wdata_reg <= wdata_i[15:0];
    end
  end

  // =====================================================
  // strobe sequencer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= pnf_pkg::PNF_IDLE;
      op <= pnf_pkg::PNF_OP_READ;
      step <= 3'd0;
      cnt <= 8'h00;
    end else begin
      case (state)
        pnf_pkg::PNF_IDLE: begin
          step <= 3'd0;
          cnt <= 8'(`PNF_PHASE_CYC);
          if (start) begin
            op <= pnf_pkg::pnf_op_t'(wdata_i[`PNF_CTRL_OP_MSB:`PNF_CTRL_OP_LSB]);
            state <= pnf_pkg::PNF_SETUP;
          end else if (hw_reset_req) begin
            cnt <= 8'(`PNF_RESET_PULSE_CYC);
            state <= pnf_pkg::PNF_HWRST;
          end
        end
        pnf_pkg::PNF_SETUP: begin
          cnt <= 8'(`PNF_PHASE_CYC);
          state <= pnf_pkg::PNF_STROBE;
        end
        pnf_pkg::PNF_STROBE: begin
          if (cnt == 8'd1) begin
            cnt <= 8'(`PNF_PHASE_CYC);
            state <= pnf_pkg::PNF_HOLD; // [R18] rising strobe here
          end else begin
            cnt <= cnt - 8'd1;
          end
        end
        pnf_pkg::PNF_HOLD: begin
          if (cnt == 8'd1) begin
            state <= pnf_pkg::PNF_NEXT;
          end else begin
            cnt <= cnt - 8'd1;
          end
        end
        pnf_pkg::PNF_NEXT: begin
          if (!is_read && step + 3'd1 < seq_len(op)) begin
            step <= step + 3'd1;
            state <= pnf_pkg::PNF_SETUP;
          end else begin
            state <= pnf_pkg::PNF_IDLE;
          end
        end
        pnf_pkg::PNF_HWRST: begin
          if (cnt == 8'd1) begin
            cnt <= `PNF_RESET_RECOVER_CYC;
            state <= pnf_pkg::PNF_RECOVER;
          end else begin
            cnt <= cnt - 8'd1;
          end
        end
        pnf_pkg::PNF_RECOVER: begin
          if (cnt == 8'd1 && rb_n) begin
            state <= pnf_pkg::PNF_IDLE; // [R11] wait for ready
          end else if (cnt != 8'd1) begin
            cnt <= cnt - 8'd1;
          end
        end
        default: state <= pnf_pkg::PNF_IDLE;
      endcase
    end
  end

  // =====================================================
  // pins
  logic [35:0] cw;
  logic strobing;
  assign cw = cyc_word(op, step, addr_reg, wdata_reg);
  assign strobing = state == pnf_pkg::PNF_STROBE;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      reset_n_o <= 1'b0;
      fa_o <= 20'h00000;
      dq_o <= 16'h0000;
      dq_oe_o <= 1'b0;
    end else begin
      reset_n_o <= !(state == pnf_pkg::PNF_HWRST); // [R9] [R10]
      // select outlasts the write strobe so command data latches on its rise
      ce_n_o <= !(strobing || state == pnf_pkg::PNF_SETUP || state == pnf_pkg::PNF_HOLD); // [R5]
      oe_n_o <= !(strobing && is_read); // [R1] [R8]
      we_n_o <= !(strobing && !is_read); // [R5]
      dq_oe_o <= (state == pnf_pkg::PNF_SETUP || strobing || state == pnf_pkg::PNF_HOLD)
                 && !is_read; // [R2]
      if (state == pnf_pkg::PNF_SETUP) begin
        fa_o <= is_read ? addr_reg : cw[35:16]; // [R13] low address bits select code
        dq_o <= cw[15:0];
      end
    end
  end

  // =====================================================
  // read capture and status
  logic sample;
  assign sample = strobing && cnt == 8'd1 && is_read;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
      done <= 1'b0;
      timeout_flag <= 1'b0;
      prev_toggle <= 1'b0;
      have_prev <= 1'b0;
    end else if (sample) begin
      rdata_reg <= id_mode ? {8'h00, dq_i[7:0]} : dq_i; // [R7] [R21]
      if (op == pnf_pkg::PNF_OP_POLL) begin
        prev_toggle <= dq_i[6];
        have_prev <= 1'b1;
        // [R19] [R16] [R17] [R22] poll bit one or toggle steady
        done <= dq_i[7] || (have_prev && prev_toggle == dq_i[6]);
        timeout_flag <= dq_i[5] && !dq_i[7]; // [R20]
      end
    end else if (start) begin
      if (wdata_i[`PNF_CTRL_OP_MSB:`PNF_CTRL_OP_LSB] != 3'(pnf_pkg::PNF_OP_POLL)) begin
        have_prev <= 1'b0;
      end
      if (!is_read) begin
        done <= 1'b0;
      end
      if (wdata_i[`PNF_CTRL_OP_MSB:`PNF_CTRL_OP_LSB] == 3'(pnf_pkg::PNF_OP_RESET)) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // identification mode tracking [R3] [R4] [R6]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      id_mode <= 1'b0;
    end else if (state == pnf_pkg::PNF_HWRST) begin
      id_mode <= 1'b0;
    end else if (state == pnf_pkg::PNF_NEXT && op == pnf_pkg::PNF_OP_ID) begin
      id_mode <= 1'b1;
    end else if (state == pnf_pkg::PNF_NEXT && op == pnf_pkg::PNF_OP_RESET) begin
      id_mode <= 1'b0; // [R14]
    end
  end

  // =====================================================
  // register reads
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `PNF_REG_CTRL: rdata_o <= {27'h0000000, id_mode, done, timeout_flag, rb_n,
                                   state != pnf_pkg::PNF_IDLE}; // [R25]
        `PNF_REG_ADDR: rdata_o <= {12'h000, addr_reg};
        `PNF_REG_WDATA: rdata_o <= {16'h0000, wdata_reg};
        `PNF_REG_RDATA: rdata_o <= {16'h0000, rdata_reg};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule : pnf_host

// file: testbench/pnf_host_monitor.sv
`timescale 1ns/10ps
// ==========
// flash pin checks
module pnf_host_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic dq_oe_o,
  input wire logic [19:0] fa_o,
  input wire logic [15:0] dq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  read_gate_a: assert property (!oe_n_o |-> !ce_n_o && we_n_o && !dq_oe_o)
    else $error("bad read pins");
  read_len_a: assert property ($fell(oe_n_o) |=> !oe_n_o [*8])
    else $error("short read strobe");
  write_gate_a: assert property (!we_n_o |-> !ce_n_o && oe_n_o && dq_oe_o)
    else $error("bad write pins");
  strobe_len_a: assert property ($fell(we_n_o) |=> !we_n_o [*8])
    else $error("short write strobe");
  unlock_one_a: assert property (!we_n_o && dq_o == 16'h00AA |-> fa_o[10:0] == 11'h555)
    else $error("bad first unlock address");
  unlock_two_a: assert property (!we_n_o && dq_o == 16'h0055 |-> fa_o[10:0] == 11'h2AA)
    else $error("bad second unlock address");
  erase_code_a: assert property (!we_n_o && dq_o == 16'h0010 |-> fa_o[10:0] == 11'h555)
    else $error("bad erase code address");
  cycle_hold_a: assert property (!we_n_o && !$past(we_n_o) |-> $stable(fa_o) && $stable(dq_o))
    else $error("write cycle changed");
endmodule : pnf_host_monitor
bind pnf_host pnf_host_monitor mon (.clk_i(clk_i), .nrst_i(nrst_i), .ce_n_o(ce_n_o),
  .oe_n_o(oe_n_o), .we_n_o(we_n_o), .dq_oe_o(dq_oe_o), .fa_o(fa_o), .dq_o(dq_o));

// file: testbench/pnf_flash_model.sv
`timescale 1ns/10ps
// ==========
// flash device model
module pnf_flash_model #(
  parameter logic [15:0] MAKER = 16'h0011, // arbitrary
  parameter logic [15:0] DEVICE = 16'h2233 // arbitrary
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic fail_i,
  input wire logic [19:0] fa_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic ready_busy_n_o
);
  logic [15:0] mem [256] = '{default: 16'hFFFF};
  logic [15:0] rv, last = 16'h0000;
  logic busy = 1'b0, fail_q = 1'b0, ers = 1'b0, idm = 1'b0, tog = 1'b0;
  int step = 0;
  realtime done_t = 0;
  localparam logic [15:0] SD [5] = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA, 16'h0055};
  localparam logic [10:0] SA [5] = '{11'h555, 11'h2AA, 11'h555, 11'h555, 11'h2AA};
  function automatic logic hit(input logic [15:0] d, input logic [10:0] a);
    return dq_i == d && fa_i[10:0] == a;
  endfunction : hit
  task automatic go(input realtime t, input logic e);
    busy = 1'b1;
    ers = e;
    done_t = $realtime + t;
  endtask : go
  always #10 if (busy && !fail_q && $realtime >= done_t) begin
    if (ers && fail_i) fail_q = 1'b1;
    else begin
      busy = 1'b0;
      if (ers) mem = '{default: 16'hFFFF};
    end
  end
  always_comb begin
    if (busy) rv = {8'h00, 1'b0, tog, fail_q, 5'h00};
    else if (idm) rv = fa_i[1] ? 16'h0000 : (fa_i[0] ? DEVICE : MAKER);
    else rv = mem[fa_i[7:0]];
  end
  assign dq_o = (!oe_n_i && !ce_n_i && reset_n_i) ? rv : ~last;
  assign ready_busy_n_o = !busy;
  always @(posedge oe_n_i) last = rv;
  always @(negedge oe_n_i) if (busy) tog = ~tog;
  always @(negedge reset_n_i) begin
    step = 0;
    idm = 1'b0;
    fail_q = 1'b0;
    ers = 1'b0;
    done_t = $realtime + 300;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && reset_n_i && (!busy || (fail_q && dq_i == 16'h00F0))) begin
      if (step == 6) begin
        mem[fa_i[7:0]] = mem[fa_i[7:0]] & dq_i;
        step = 0;
        go(200, 1'b0);
      end else if (dq_i == 16'h00F0) begin
        step = 0;
        idm = 1'b0;
        fail_q = 1'b0;
        busy = 1'b0;
      end else if (step == 2 && hit(16'h0090, 11'h555)) begin
        idm = 1'b1;
        step = 0;
      end else if (step == 2 && hit(16'h00A0, 11'h555)) step = 6;
      else if (step == 5 && hit(16'h0010, 11'h555)) begin
        step = 0;
        go(5000, 1'b1);
      end else if (step < 5 && hit(SD[step], SA[step])) step++;
      else step = 0;
    end
  end
endmodule : pnf_flash_model

// file: testbench/tb.sv
`timescale 1ns/10ps
// ==========
// bench top
module tb;
  logic clk_i, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, ck = 1'b0, ck_d = 1'b0;
  logic ce_n, oe_n, we_n, rs_n, dq_oe, rb_n, fail = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, last, a, d, seed = 32'h3A;
  logic [31:0] eq[$], mq[$];
  logic [19:0] fa;
  logic [15:0] h_dq, f_dq, dq;
  int fail_count = 0, cmp_count = 0, n;
  assign dq = dq_oe ? h_dq : f_dq;
  pnf_host dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .reset_n_o(rs_n), .fa_o(fa), .dq_o(h_dq), .dq_oe_o(dq_oe),
    .dq_i(dq), .ready_busy_n_i(rb_n));
  pnf_flash_model flash (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .reset_n_i(rs_n),
    .fail_i(fail), .fa_i(fa), .dq_i(dq), .dq_o(f_dq), .ready_busy_n_o(rb_n));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic cmp(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
    cmp_count++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask : cmp
  task automatic complete_run();
    $display("mismatches=%0d compares=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic bus(input logic [3:0] ad, input logic [31:0] wd, input logic w, input logic c);
    addr_i <= ad;
    wdata_i <= wd;
    wr_i <= w;
    rd_i <= !w;
    ck <= c;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rdc(input logic [3:0] ad, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    bus(ad, 32'h0, 1'b0, 1'b1);
  endtask : rdc
  // control write, then status polls until masked status matches
  task automatic op(input logic [31:0] c, input logic [31:0] m, input logic [31:0] e);
    int i;
    bus(4'h0, c, 1'b1, 1'b0);
    last = ~e;
    for (i = 0; i < 3000 && (last & m) !== e; i++) bus(4'h0, 32'h0, 1'b0, 1'b0);
    if (i == 3000) fail_count++;
  endtask : op
  task automatic rda(input logic [31:0] ad, input logic [31:0] e);
    bus(4'h4, ad, 1'b1, 1'b0);
    op(32'h0, 32'h3, 32'h2);
    rdc(4'hC, e, 32'hFFFF);
  endtask : rda
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    ck_d <= ck;
  end
  always @(negedge clk_i) begin
    if (rd_d === 1'b1) begin
      last = rdata_o;
      if (ck_d === 1'b1) cmp(eq.pop_front(), mq.pop_front(), rdata_o);
    end
  end
  initial begin
    #300000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdc(4'h0, 32'h0, 32'h15);
    rdc(4'h2, 32'h0, 32'hFFFFFFFF);
    a = xs();
    // poll bit of programmed word kept low so completion needs the toggle path
    d = (xs() | 32'h8000) & 32'hFFFFFF7F;
    rda(a, 32'hFFFF);
    bus(4'h8, d, 1'b1, 1'b0);
    op(32'h3, 32'h3, 32'h2);
    rda(a, d & 32'hFFFF);
    op(32'h5, 32'h3, 32'h2);
    rdc(4'h0, 32'h0, 32'h8);
    op(32'h5, 32'h3, 32'h2);
    rdc(4'h0, 32'h8, 32'h8);
    op(32'h2, 32'h3, 32'h2);
    rdc(4'h0, 32'h10, 32'h10);
    rda(32'h0, 32'h11);
    rda(32'h1, 32'h33);
    op(32'h1, 32'h3, 32'h2);
    rda(a, d & 32'hFFFF);
    op(32'h4, 32'h3, 32'h2);
    rda(a, 32'hFFFF);
    op(32'h5, 32'h3, 32'h2);
    rdc(4'h0, 32'h8, 32'h8);
    bus(4'h8, d, 1'b1, 1'b0);
    op(32'h3, 32'h3, 32'h2);
    fail <= 1'b1;
    op(32'h4, 32'h1, 32'h0);
    for (n = 0; n < 60 && last[2] !== 1'b1; n++) op(32'h5, 32'h1, 32'h0);
    rdc(4'h0, 32'h4, 32'hC);
    fail <= 1'b0;
    op(32'h1, 32'h3, 32'h2);
    rdc(4'h0, 32'h0, 32'h4);
    rda(a, d & 32'hFFFF);
    op(32'h4, 32'h1, 32'h0);
    op(32'h8, 32'h3, 32'h2);
    rda(a, d & 32'hFFFF);
    op(32'h4, 32'h3, 32'h2);
    rda(a, 32'hFFFF);
    complete_run();
  end
endmodule : tb
